// ---- common/lvd_pkg.sv ----
// package: register map, field positions and reset values of the low-voltage detect control
// How it works
// - control bit 1 set gives reset mode, clear gives interrupt mode.
// - control bit 2 picks supply comparator (0) or external pin comparator (1).
// - reset mode: internal reset held while selected input is below level.
// - interrupt mode: interrupt on both falling-below and rising-to-level crossings.
// - control bit 0 is a read-only live below-level flag while enabled.
// - control bit 7 set starts the comparator and detection.
// - level select register bits 3..0 choose the supply threshold.
// - setting mode bit while at or above level gives no reset.
// - interrupt mode: disabling while below level raises an interrupt and request flag.
// - any reset generation sets the detector interrupt mask.
// - a detector reset is recorded in reset cause register bit 0.
// - enable, mode and source bits survive a detector reset only.
// - level select register survives a detector reset only.
// - the flag drives the interrupt only in interrupt mode, while enabled or in the cycle after enable is cleared.
package lvd_pkg;
  // byte offsets on the apb bus
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_LEVEL = 8'h04;
  localparam logic [7:0] OFS_IRQ = 8'h08;
  localparam logic [7:0] OFS_CAUSE = 8'h0c;
  // detect_control_reg fields
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_SOURCE_BIT = 2;
  localparam int CTL_MODE_BIT = 1;
  localparam int CTL_FLAG_BIT = 0;
  // level_select_reg field
  localparam int LEVEL_WIDTH = 4;
  localparam logic [3:0] LEVEL_RESET = 4'h0;
  // interrupt register fields
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_MASK_BIT = 1;
  // reset_cause_reg field
  localparam int CAUSE_BIT = 0;
  // data width and reset values
  localparam int DATA_WIDTH = 32;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  localparam logic CTL_BIT_RESET = 1'b0;
  localparam logic MASK_RESET = 1'b1;
endpackage

// ---- verilog/lvd_sync.sv ----
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module lvd_sync
  import lvd_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // level in and out
  input wire logic async_in,
  output logic sync_out
);
  logic meta;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ---- verilog/lvd_ctrl.sv ----
// low-voltage detect control: apb registers, source select, reset and interrupt generation
`timescale 1ns/1ps
module lvd_ctrl
  import lvd_pkg::*;
(
  // apb clock and system reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog comparator side, high means below level
  input wire logic supply_below_async,
  input wire logic external_below_async,
  output logic comparator_enable,
  output logic [3:0] supply_threshold,
  // system side
  output logic detect_reset,
  output logic detect_irq,
  output logic detect_irq_pending
);
  // control state
  logic detect_enable;
  logic detect_mode_select;
  logic detect_source_select;
  logic [3:0] level_select_field;
  logic detect_irq_request_flag;
  logic detect_irq_mask;
  logic detect_reset_cause_flag;
  // synchronised comparator levels
  logic supply_below;
  logic external_below;
  logic selected_below;
  logic below_level_flag;
  logic flag_q;
  logic enable_q;
  logic irq_event;
  logic next_reset;
  // bus decode
  logic setup_phase;
  logic access_wr;
  logic access_rd;
  logic addr_hit;
  logic sel_control;
  logic sel_level;
  logic sel_irq;
  logic sel_cause;
  logic [31:0] next_prdata;

  // comparator levels brought into the clock domain
  lvd_sync u_sync_supply (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(supply_below_async),
    .sync_out(supply_below)
  );

  lvd_sync u_sync_external (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(external_below_async),
    .sync_out(external_below)
  );

  // source choice and live flag
  assign selected_below = detect_source_select ? external_below : supply_below;
  assign below_level_flag = detect_enable & selected_below;

  // crossing detect, also catches the drop when enable is cleared
  assign irq_event = (below_level_flag != flag_q) & ~detect_mode_select
                     & (detect_enable | enable_q);

  // reset request only while enabled in reset mode and below
  assign next_reset = detect_enable & detect_mode_select & selected_below;

  // register selects
  assign sel_control = (paddr == OFS_CONTROL);
  assign sel_level = (paddr == OFS_LEVEL);
  assign sel_irq = (paddr == OFS_IRQ);
  assign sel_cause = (paddr == OFS_CAUSE);

  // apb phases, the slave never stretches
  assign setup_phase = psel & ~penable;
  assign access_wr = psel & penable & pwrite;
  assign access_rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign addr_hit = sel_control | sel_level | sel_irq | sel_cause;
  assign pslverr = psel & penable & ~addr_hit;

  // analog side
  assign comparator_enable = detect_enable;
  assign supply_threshold = level_select_field;
  assign detect_irq_pending = detect_irq_request_flag & ~detect_irq_mask;

  // history for the crossing detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
      enable_q <= 1'b0;
    end else begin
      flag_q <= below_level_flag;
      enable_q <= detect_enable;
    end
  end

  // control bits, untouched by the detector's own reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_enable <= CTL_BIT_RESET;
      detect_mode_select <= CTL_BIT_RESET;
      detect_source_select <= CTL_BIT_RESET;
    end else if (access_wr && sel_control) begin
      detect_enable <= pwdata[CTL_ENABLE_BIT];
      detect_mode_select <= pwdata[CTL_MODE_BIT];
      detect_source_select <= pwdata[CTL_SOURCE_BIT];
    end
  end

  // threshold code, kept over a detector reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_select_field <= LEVEL_RESET;
    end else if (access_wr && sel_level) begin
      level_select_field <= pwdata[LEVEL_WIDTH-1:0];
    end
  end

  // internal reset output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_reset <= 1'b0;
    end else begin
      detect_reset <= next_reset;
    end
  end

  // interrupt pulse, one cycle per crossing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_irq <= 1'b0;
    end else begin
      detect_irq <= irq_event;
    end
  end

  // request flag: a crossing wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_irq_request_flag <= 1'b0;
    end else if (irq_event) begin
      detect_irq_request_flag <= 1'b1;
    end else if (access_wr && paddr == OFS_IRQ) begin
      detect_irq_request_flag <= pwdata[IRQ_FLAG_BIT];
    end
  end

  // mask: set by any reset, including the detector's
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_irq_mask <= MASK_RESET;
    end else if (detect_reset) begin
      detect_irq_mask <= 1'b1;
    end else if (access_wr && paddr == OFS_IRQ) begin
      detect_irq_mask <= pwdata[IRQ_MASK_BIT];
    end
  end

  // reset cause: set by detector reset, cleared when read
  // only a cause already reported is cleared, so a set between setup and access survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_reset_cause_flag <= 1'b0;
    end else if (detect_reset) begin
      detect_reset_cause_flag <= 1'b1;
    end else if (access_rd && sel_cause && prdata[CAUSE_BIT]) begin
      detect_reset_cause_flag <= 1'b0;
    end
  end

  // read mux, sampled in the setup phase
  always_comb begin
    next_prdata = DATA_ZERO;
    unique case (paddr)
      OFS_CONTROL: begin
        next_prdata[CTL_ENABLE_BIT] = detect_enable;
        next_prdata[CTL_SOURCE_BIT] = detect_source_select;
        next_prdata[CTL_MODE_BIT] = detect_mode_select;
        next_prdata[CTL_FLAG_BIT] = below_level_flag;
      end
      OFS_LEVEL: begin
        next_prdata[LEVEL_WIDTH-1:0] = level_select_field;
      end
      OFS_IRQ: begin
        next_prdata[IRQ_FLAG_BIT] = detect_irq_request_flag;
        next_prdata[IRQ_MASK_BIT] = detect_irq_mask;
      end
      OFS_CAUSE: begin
        next_prdata[CAUSE_BIT] = detect_reset_cause_flag;
      end
      default: begin
        next_prdata = DATA_ZERO;
      end
    endcase
  end

  // read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= DATA_ZERO;
    end else if (setup_phase && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // checks on the detection behaviour
  a_reset_follows: assert property (@(posedge pclk) disable iff (!presetn)
    (detect_enable && detect_mode_select && selected_below) |=> detect_reset)
    else $error("reset not raised while below level in reset mode");

  a_reset_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !(detect_enable && detect_mode_select && selected_below) |=> !detect_reset)
    else $error("reset raised while at level or not in reset mode");

  a_irq_crossing: assert property (@(posedge pclk) disable iff (!presetn)
    (detect_enable && enable_q && !detect_mode_select && $changed(below_level_flag)) |=> detect_irq)
    else $error("crossing in interrupt mode gave no interrupt");

  a_irq_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    detect_irq |-> detect_irq_request_flag)
    else $error("interrupt pulse without request flag");

  a_disable_below: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(detect_enable) && flag_q && !detect_mode_select) |=> (detect_irq && detect_irq_request_flag))
    else $error("disable below level gave no interrupt");

  a_reset_mode_silent: assert property (@(posedge pclk) disable iff (!presetn)
    detect_mode_select |=> !detect_irq)
    else $error("interrupt pulse in reset mode");

  a_mask_on_reset: assert property (@(posedge pclk) disable iff (!presetn)
    detect_reset |=> detect_irq_mask)
    else $error("mask not set by detector reset");

  a_cause_on_reset: assert property (@(posedge pclk) disable iff (!presetn)
    detect_reset |=> detect_reset_cause_flag)
    else $error("reset cause not recorded");

  a_flag_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    !detect_enable |-> !below_level_flag)
    else $error("level flag set while disabled");

  a_sync_latency: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(supply_below_async) ##1 supply_below_async |=> supply_below)
    else $error("supply level not through two stages");

  // checks on the register side
  a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access_wr && sel_control) |=> (detect_enable == $past(pwdata[CTL_ENABLE_BIT])))
    else $error("enable bit not taken from the write");

  a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access_wr && sel_control) |=> (detect_mode_select == $past(pwdata[CTL_MODE_BIT])))
    else $error("mode bit not taken from the write");

  a_source_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access_wr && sel_control) |=> (detect_source_select == $past(pwdata[CTL_SOURCE_BIT])))
    else $error("source bit not taken from the write");

  a_level_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access_wr && sel_level) |=> (supply_threshold == $past(pwdata[LEVEL_WIDTH-1:0])))
    else $error("threshold code not taken from the write");

  a_flag_readback: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && sel_control) |=> (prdata[CTL_FLAG_BIT] == $past(below_level_flag)))
    else $error("level flag not returned on read");

  a_mode_readback: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && sel_control) |=> (prdata[CTL_MODE_BIT] == $past(detect_mode_select)))
    else $error("mode bit not returned on read");

  a_level_readback: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && sel_level) |=> (prdata[LEVEL_WIDTH-1:0] == $past(level_select_field)))
    else $error("threshold code not returned on read");

  a_flag_write_set: assert property (@(posedge pclk) disable iff (!presetn)
    (access_wr && sel_irq && pwdata[IRQ_FLAG_BIT]) |=> detect_irq_request_flag)
    else $error("request flag not set by write");

  a_flag_write_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (access_wr && sel_irq && !pwdata[IRQ_FLAG_BIT] && !irq_event) |=> !detect_irq_request_flag)
    else $error("request flag not cleared by write");

  a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access_wr && sel_irq && !detect_reset) |=> (detect_irq_mask == $past(pwdata[IRQ_MASK_BIT])))
    else $error("mask not taken from the write");

  a_pending_masked: assert property (@(posedge pclk) disable iff (!presetn)
    detect_irq_mask |-> !detect_irq_pending)
    else $error("pending shown while masked");

  a_cause_held: assert property (@(posedge pclk) disable iff (!presetn)
    (detect_reset_cause_flag && !(access_rd && sel_cause)) |=> detect_reset_cause_flag)
    else $error("reset cause lost without a read");

  a_cause_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (access_rd && sel_cause && prdata[CAUSE_BIT] && !detect_reset) |=> !detect_reset_cause_flag)
    else $error("reported reset cause not cleared");

  // checks on the comparator path
  a_supply_source: assert property (@(posedge pclk) disable iff (!presetn)
    (detect_enable && !detect_source_select) |-> (below_level_flag == supply_below))
    else $error("flag does not follow the supply comparator");

  a_ext_source: assert property (@(posedge pclk) disable iff (!presetn)
    (detect_enable && detect_source_select) |-> (below_level_flag == external_below))
    else $error("flag does not follow the external comparator");

  a_reset_release: assert property (@(posedge pclk) disable iff (!presetn)
    (detect_reset && !selected_below) |=> !detect_reset)
    else $error("reset held after level recovered");

  a_irq_steady: assert property (@(posedge pclk) disable iff (!presetn)
    !$changed(below_level_flag) |=> !detect_irq)
    else $error("interrupt pulse without a crossing");

  a_quiet_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    (!detect_enable && !enable_q) |=> !detect_irq)
    else $error("interrupt pulse while detection off");

  a_sync_external: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(external_below_async) ##1 external_below_async |=> external_below)
    else $error("external level not through two stages");

  a_sync_fall: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(supply_below_async) ##1 !supply_below_async |=> !supply_below)
    else $error("supply recovery not through two stages");

  // main scenarios
  c_reset_mode: cover property (@(posedge pclk) disable iff (!presetn) $rose(detect_reset));
  c_irq_fall: cover property (@(posedge pclk) disable iff (!presetn) detect_irq && below_level_flag);
  c_irq_rise: cover property (@(posedge pclk) disable iff (!presetn) detect_irq && !flag_q && detect_enable);
  c_disable_irq: cover property (@(posedge pclk) disable iff (!presetn) $fell(detect_enable) ##1 detect_irq);
  c_source_ext: cover property (@(posedge pclk) disable iff (!presetn) detect_irq && detect_source_select);
endmodule

// ---- test/lvd_comp_model.sv ----
// comparator model: async below-level outputs that lag the requested levels
`timescale 1ns/1ps
module lvd_comp_model
  import lvd_pkg::*;
(
  // requested levels from the bench, high means below
  input wire logic supply_low,
  input wire logic external_low,
  // async comparator outputs
  output logic supply_below_async,
  output logic external_below_async
);
  // lag keeps every change away from the clock edge
  assign #3.3 supply_below_async = supply_low;
  assign #7.1 external_below_async = external_low;
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the low-voltage detect control
`timescale 1ns/1ps
module tb_top;
  import lvd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sup_low, ext_low, sup_async, ext_async, comp_en, det_rst, det_irq, pend;
  logic [3:0] thr;
  int n_mismatch, check_count, irq_count, base;

  lvd_ctrl u_lvd_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_below_async(sup_async), .external_below_async(ext_async), .comparator_enable(comp_en),
    .supply_threshold(thr), .detect_reset(det_rst), .detect_irq(det_irq), .detect_irq_pending(pend));
  lvd_comp_model u_lvd_comp_model (.supply_low(sup_low), .external_low(ext_low),
    .supply_below_async(sup_async), .external_below_async(ext_async));

  // clock and interrupt pulse counter
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) if (det_irq === 1'b1) irq_count++;

  task complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      n_mismatch++;
      complete_run;
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // write, then one edge so later checks see the stored value
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge pclk);
  endtask
  task rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  // comparator lag plus two sync flops plus one output flop
  task settle;
    repeat (6) @(posedge pclk);
  endtask
  task do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  task t_reset_vals;
    rdc("control", OFS_CONTROL, 32'h0);
    rdc("level", OFS_LEVEL, 32'h0);
    rdc("irq reg", OFS_IRQ, 32'h2);
    rdc("cause", OFS_CAUSE, 32'h0);
    chk("reset out", 32'h0, det_rst);
  endtask
  task t_regs;
    wr(OFS_LEVEL, 32'hff);
    rdc("level", OFS_LEVEL, 32'hf);
    chk("threshold", 32'hf, thr);
    wr(8'h10, 32'hff);
    chk("slverr", 32'h1, err);
    rdc("unmapped", 8'h10, 32'h0);
  endtask
  task t_irq_mode;
    wr(OFS_CONTROL, 32'h80);
    repeat (500) @(posedge pclk);
    chk("enable out", 32'h1, comp_en);
    base = irq_count;
    sup_low <= 1'b1;
    settle;
    chk("fall irq", base + 1, irq_count);
    rdc("flag low", OFS_CONTROL, 32'h81);
    rdc("irq reg", OFS_IRQ, 32'h3);
    wr(OFS_IRQ, 32'h0);
    chk("pending", 32'h0, pend);
    sup_low <= 1'b0;
    settle;
    chk("rise irq", base + 2, irq_count);
    chk("pending", 32'h1, pend);
    rdc("flag ok", OFS_CONTROL, 32'h80);
  endtask
  task t_disable_low;
    sup_low <= 1'b1;
    settle;
    wr(OFS_IRQ, 32'h0);
    base = irq_count;
    wr(OFS_CONTROL, 32'h0);
    settle;
    chk("disable irq", base + 1, irq_count);
    chk("pending", 32'h1, pend);
    rdc("flag off", OFS_CONTROL, 32'h0);
    sup_low <= 1'b0;
  endtask
  task t_source;
    wr(OFS_CONTROL, 32'h84);
    ext_low <= 1'b1;
    settle;
    rdc("ext low", OFS_CONTROL, 32'h85);
    ext_low <= 1'b0;
    sup_low <= 1'b1;
    settle;
    rdc("ext ok", OFS_CONTROL, 32'h84);
    sup_low <= 1'b0;
    wr(OFS_CONTROL, 32'h0);
  endtask
  task t_reset_mode;
    wr(OFS_IRQ, 32'h2);
    wr(OFS_CONTROL, 32'h80);
    repeat (500) @(posedge pclk);
    rdc("poll", OFS_CONTROL, 32'h80);
    wr(OFS_IRQ, 32'h0);
    wr(OFS_CONTROL, 32'h82);
    settle;
    chk("no reset", 32'h0, det_rst);
    base = irq_count;
    sup_low <= 1'b1;
    settle;
    chk("reset on", 32'h1, det_rst);
    chk("no irq", base, irq_count);
    rdc("mask set", OFS_IRQ, 32'h2);
    sup_low <= 1'b0;
    settle;
    chk("reset off", 32'h0, det_rst);
    rdc("cause", OFS_CAUSE, 32'h1);
    rdc("cause cleared", OFS_CAUSE, 32'h0);
    rdc("kept", OFS_CONTROL, 32'h82);
    rdc("level kept", OFS_LEVEL, 32'hf);
    wr(OFS_CONTROL, 32'h80);
    wr(OFS_CONTROL, 32'h0);
    chk("enable off", 32'h0, comp_en);
  endtask
  // system reset in mid-run with control bits set and the mask released
  task t_sys_reset;
    wr(OFS_CONTROL, 32'h84);
    wr(OFS_IRQ, 32'h0);
    rdc("irq before reset", OFS_IRQ, 32'h0);
    do_reset;
    rdc("level cleared", OFS_LEVEL, 32'h0);
    rdc("control cleared", OFS_CONTROL, 32'h0);
    rdc("mask after reset", OFS_IRQ, 32'h2);
  endtask

  // guard against a hang
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    complete_run;
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, sup_low, ext_low} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_vals;
    t_regs;
    t_irq_mode;
    t_disable_low;
    t_source;
    t_reset_mode;
    t_sys_reset;
    complete_run;
  end
endmodule
